// [core/swp_pkg.sv]
package swp_pkg;
  // command words, first byte in the top bits, as they leave the shift register
  localparam logic [31:0] CMD_ENABLE = 32'h3d2a7fa9;
  localparam logic [31:0] CMD_DISABLE = 32'h3d2a7f9a;
  localparam logic [31:0] CMD_MAP_ERASE = 32'h3d2a7fcf;
  localparam int CMD_W = 32;
  localparam int BITCNT_W = 6;
  localparam logic [BITCNT_W-1:0] CMD_BITS = 6'h20;
  localparam logic [BITCNT_W-1:0] CMD_SAT = 6'h21;
  // protection map: sector n in bits 8n+7..8n
  localparam int MAP_W = 32;
  localparam int BYTE_W = 8;
  localparam int SECTORS = 4;
  localparam logic [MAP_W-1:0] MAP_RESET = 32'h00000000;
  localparam logic [MAP_W-1:0] MAP_ERASED = 32'hffffffff;
  localparam logic [BYTE_W-1:0] SEC_ON = 8'hff;
  localparam int S0A_HI = 7;
  localparam int S0A_LO = 6;
  localparam int S0B_HI = 5;
  localparam int S0B_LO = 4;
  localparam logic [1:0] PAIR_ON = 2'h3;
  // synchroniser lanes and their idle levels
  localparam int PIN_WP = 3;
  localparam int PIN_CS = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 0;
  localparam logic [3:0] PIN_IDLE = 4'hc;
  // timing at the 100 MHz system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int WP_FILTER_NS = 100;
  localparam int WPF_CYC = (WP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLT_W = 4;
  localparam int PROTECT_ON_DELAY_NS = 1000;
  localparam int PROTECT_ON_CYC = PROTECT_ON_DELAY_NS / CLK_PERIOD_NS;
  localparam int PROTECT_OFF_DELAY_NS = 1000;
  localparam int PROTECT_OFF_CYC = PROTECT_OFF_DELAY_NS / CLK_PERIOD_NS;
  localparam int MAP_ERASE_TIME_US = 100;
  localparam int MAP_ERASE_CYC = MAP_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ERS_W = 24;
  typedef enum logic [0:0] {ST_IDLE, ST_ERASE} swp_state_type;
endpackage

// [core/swp_sector_write_protect.sv]
`timescale 1ns/1ps
// How it works
// - held wp blocks map and protected sectors
// - map programs and erase starts accepted only while wp released
// - wp assertion turns protection on promptly
// - wp release turns protection off promptly
// - enable command survives wp release
// - disable command ignored while wp asserted
// - wp passes a stability noise filter
// - four map bytes, byte n for sector n
// - sectors 1-3: ff protected, 00 not
// - sector 0 bit pairs guard 0a, 0b
// - map starts all zero
// - map erase opcode starts on cs rise
// - busy shown during map erase
// - map erase allowed with software protection on or off, not under wp
// - erased map, with protection on, refuses every array program or erase
// - enable opcode acts on cs rise
// - disable opcode acts on cs rise
// - software protection cleared at reset
module swp_sector_write_protect #(
  parameter int MAP_ERASE_CYC = swp_pkg::MAP_ERASE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wp_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_op_req,
  input wire logic i_op_map,
  input wire logic [1:0] i_op_sector,
  input wire logic i_op_page_hi,
  input wire logic [swp_pkg::MAP_W-1:0] i_op_wdata,
  output logic o_op_grant,
  output logic o_op_deny,
  output logic o_protect_on,
  output logic o_busy,
  output logic o_wp_filtered,
  output logic [swp_pkg::MAP_W-1:0] o_map,
  output logic [swp_pkg::SECTORS:0] o_sector_prot
);
  import swp_pkg::*;

  // sector guard decode, shared by request check and the sector flags below
  // sector 0 ignores its low nibble; other sectors need the full erased byte
  function automatic logic sec_prot(input logic [MAP_W-1:0] m, input logic [1:0] s, input logic hi);
    logic [BYTE_W-1:0] b;
    b = m[s*BYTE_W +: BYTE_W];
    if (s == 2'h0) begin
      sec_prot = hi ? (b[S0B_HI:S0B_LO] == PAIR_ON) : (b[S0A_HI:S0A_LO] == PAIR_ON);
    end else begin
      sec_prot = (b == SEC_ON);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // every pin is asynchronous to the system clock, so all four share one
  // two-stage chain; the third stage only serves the edge detectors
  // idle levels at reset keep a false cs or sck edge from following reset
  logic [3:0] pins_s1; // first stage, read only by the second
  logic [3:0] pins_s2; // settled pin levels
  logic [3:0] pins_s3; // one cycle older, for edges
  wire [3:0] pins_raw = {i_wp_n, i_cs_n, i_sck, i_si};

  // sck runs far below the system clock, so edges are found by sampling
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pins_s1 <= PIN_IDLE;
      pins_s2 <= PIN_IDLE;
      pins_s3 <= PIN_IDLE;
    end else if (i_ce) begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
    end
  end

  // edges compare the settled stage with the one before it
  wire wp_in = ~pins_s2[PIN_WP]; // wp asserted level
  wire sck_rise = pins_s2[PIN_SCK] & ~pins_s3[PIN_SCK];
  wire cs_fall = ~pins_s2[PIN_CS] & pins_s3[PIN_CS];
  wire cs_rise = pins_s2[PIN_CS] & ~pins_s3[PIN_CS];
  wire cs_active = ~pins_s2[PIN_CS];

  ////////////////////////////////////////////////////////////////////////////
  // wp noise filter: a new level must hold for the whole filter window
  logic wp_f; // filtered wp asserted
  logic [FLT_W-1:0] flt_cnt; // cycles the new level has held
  wire flt_done = (flt_cnt == FLT_W'(WPF_CYC - 1));

  // a glitch shorter than the window restarts the count and is lost
  // the window costs latency on every real wp change, which the on and off
  // delay budgets absorb with plenty of room
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_f <= 1'b0;
      flt_cnt <= '0;
    end else if (i_ce) begin
      if (wp_in == wp_f) begin
        flt_cnt <= '0;
      end else if (flt_done) begin
        wp_f <= wp_in;
        flt_cnt <= '0;
      end else begin
        flt_cnt <= flt_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // opcode shifter, msb first on sck rise
  // the counter saturates so that an over-long frame never wraps back to a
  // count of exactly one opcode and gets mistaken for a clean command
  logic [CMD_W-1:0] shreg; // last bits shifted in
  logic [BITCNT_W-1:0] bitcnt; // saturates one past a full opcode

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg <= '0;
      bitcnt <= '0;
    end else if (i_ce) begin
      if (cs_fall) begin
        bitcnt <= '0;
      end else if (sck_rise && cs_active) begin
        shreg <= {shreg[CMD_W-2:0], pins_s2[PIN_SI]};
        if (bitcnt != CMD_SAT) begin
          bitcnt <= bitcnt + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode at chip select release
  // a command counts only when exactly one opcode arrived in the frame, and
  // nothing is decoded while the map erase runs
  swp_state_type state; // map erase state
  wire busy = (state == ST_ERASE);
  wire cmd_full = cs_rise && (bitcnt == CMD_BITS) && !busy;
  wire hit_en = cmd_full && (shreg == CMD_ENABLE);
  wire hit_dis = cmd_full && (shreg == CMD_DISABLE);
  wire hit_ers = cmd_full && (shreg == CMD_MAP_ERASE);
  wire ers_go = hit_ers && !wp_f;

  logic sw_en; // protection enabled by command

  // wp never touches this flag, so an enable given under wp outlives it
  // an enable and a disable cannot fall in one cycle: one command per frame
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_en <= 1'b0;
    end else if (i_ce) begin
      if (hit_en) begin
        sw_en <= 1'b1;
      end else if (hit_dis && !wp_f) begin
        sw_en <= 1'b0;
      end
    end
  end

  wire prot_active = sw_en | wp_f;

  ////////////////////////////////////////////////////////////////////////////
  // program and erase requests from the array side
  // the answer is one registered pulse, grant or deny, never both
  wire tgt_prot = sec_prot(o_map, i_op_sector, i_op_page_hi);
  // the map may be programmed with protection on, but never under wp
  wire op_ok = !busy && (i_op_map ? !wp_f : !(prot_active && tgt_prot));
  // a granted map program lands on the same edge as its grant pulse, except when a map erase starts on that edge
  wire map_wr = i_op_req && op_ok && i_op_map;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_op_grant <= 1'b0;
      o_op_deny <= 1'b0;
    end else if (i_ce) begin
      o_op_grant <= i_op_req && op_ok;
      o_op_deny <= i_op_req && !op_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // map storage and self-timed erase
  logic [ERS_W-1:0] ers_cnt; // erase cycles left
  wire ers_last = (ers_cnt == '0);

  // programming only clears bits; setting them back needs the erase
  // the map flips to all ones only as the erase ends, so no request ever sees
  // a half-erased map
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      ers_cnt <= '0;
      o_map <= MAP_RESET;
    end else if (i_ce) begin
      unique case (state)
        ST_IDLE: begin
          if (ers_go) begin
            state <= ST_ERASE;
            ers_cnt <= ERS_W'(MAP_ERASE_CYC - 1);
          end else if (map_wr) begin
            o_map <= o_map & i_op_wdata;
          end
        end
        ST_ERASE: begin
          if (ers_last) begin
            state <= ST_IDLE;
            o_map <= MAP_ERASED;
          end else begin
            ers_cnt <= ers_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  // protect and wp flags registered so that the pins see clean levels; this adds one cycle of delay; busy and sector flags are not
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_protect_on <= 1'b0;
      o_wp_filtered <= 1'b0;
    end else if (i_ce) begin
      o_protect_on <= prot_active;
      o_wp_filtered <= wp_f;
    end
  end

  assign o_busy = busy;
  // flag 0 is subsector 0a; flags 1 to 4 use the high-page decode, which
  // only sector 0 tells apart, so flag 1 comes out as subsector 0b
  assign o_sector_prot[0] = sec_prot(o_map, 2'h0, 1'b0);
  genvar gi;
  generate
    for (gi = 0; gi < SECTORS; gi++) begin : g_sec
      assign o_sector_prot[gi+1] = sec_prot(o_map, 2'(gi), 1'b1);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // long holds are counted by helper counters rather than long repetitions,
  // which keeps the properties cheap; the two sync cycles come off each bound
  localparam int c_on_max = PROTECT_ON_CYC - 2;
  localparam int c_off_max = PROTECT_OFF_CYC - 2;
  logic [7:0] lo_cnt; // cycles synced wp held asserted
  logic [7:0] hi_cnt; // cycles synced wp held released

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_cnt <= '0;
      hi_cnt <= '0;
    end else if (i_ce) begin
      lo_cnt <= !wp_in ? '0 : (lo_cnt == 8'hff ? lo_cnt : lo_cnt + 1'b1);
      hi_cnt <= wp_in ? '0 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 1'b1);
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  wire map_req = i_ce && i_op_req && i_op_map; // map program attempt
  wire map_all_on = (o_map == MAP_ERASED); // every guard bit set

  // an erase started before wp may still finish and rewrite the map
  wp_map_lock_a: assert property (map_req && wp_f && !busy |=> o_op_deny && $stable(o_map))
    else $error("map changed under wp");
  wp_map_free_a: assert property (map_req && !wp_f && !busy |=> o_op_grant)
    else $error("map write refused without wp");
  wp_on_a: assert property (i_ce && lo_cnt > c_on_max |-> o_protect_on)
    else $error("wp did not enable protection in time");
  wp_off_a: assert property (i_ce && hi_cnt > c_off_max && !sw_en |=> !o_protect_on)
    else $error("protection stayed on after wp release");
  sw_keep_a: assert property (i_ce && sw_en |=> o_protect_on)
    else $error("enabled protection dropped");
  dis_ignore_a: assert property (i_ce && hit_dis && wp_f |=> sw_en == $past(sw_en))
    else $error("disable acted under wp");
  wp_filter_a: assert property ($changed(wp_f) |-> $past(wp_in, 1) == wp_f && $past(wp_in, 2) == wp_f)
    else $error("wp glitch passed the filter");
  ers_busy_a: assert property (i_ce && ers_go |=> o_busy)
    else $error("map erase did not show busy");
  ers_fill_a: assert property ($fell(o_busy) |-> o_map == MAP_ERASED)
    else $error("erase did not set every map bit");
  erased_deny_a: assert property (i_ce && i_op_req && !i_op_map && prot_active && map_all_on |=> o_op_deny)
    else $error("request passed an erased map");
  part_cmd_a: assert property (i_ce && cs_rise && bitcnt != CMD_BITS |=> $stable(sw_en) && !$rose(o_busy))
    else $error("partial opcode acted");
  ers_any_a: assert property (i_ce && hit_ers && !wp_f && sw_en |=> o_busy)
    else $error("map erase refused with protection on");

  en_cmd_c: cover property (hit_en && wp_f);
  ers_run_c: cover property ($fell(o_busy));
  deny_c: cover property (o_op_deny && !wp_f);
  wp_hand_c: cover property ($fell(wp_f) && sw_en);
  ers_prot_c: cover property (hit_ers && sw_en && !wp_f);

endmodule // swp_sector_write_protect

// [dv/swp_host_model.sv]
`timescale 1ns/1ps
// host side of the serial command link; sck rests low between frames
module swp_host_model (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  //////////////////////////////////////////////
  // one framed word, msb first; fewer bits make a cut-short frame
  task automatic send(input logic [31:0] word, input int nbits);
    o_cs_n = 1'b0;
    #62.5;
    for (int i = 31; i > 31 - nbits; i--) begin
      o_si = word[i];
      #62.5 o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
    #62.5 o_cs_n = 1'b1;
    // released data line must not hold its last bit
    o_si = ~o_si;
  endtask
endmodule // swp_host_model

// [dv/swp_tb.sv]
`timescale 1ns/1ps
module tb;
  import swp_pkg::*;
  localparam int ERS_CYC = 20; // shortened erase so the run stays brief
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wp_n = 1'b1;
  logic i_op_req = 1'b0;
  logic i_op_map = 1'b0;
  logic [1:0] i_op_sector = 2'h0;
  logic i_op_page_hi = 1'b0;
  logic [MAP_W-1:0] i_op_wdata = 32'h0;
  logic cs_n, sck, si, o_op_grant, o_op_deny, o_protect_on, o_busy, o_wp_filtered;
  logic [MAP_W-1:0] o_map;
  logic [SECTORS:0] o_sector_prot;
  int err_count = 0;
  int n_compared = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  swp_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  swp_sector_write_protect #(.MAP_ERASE_CYC(ERS_CYC)) DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_wp_n(i_wp_n), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_op_req(i_op_req), .i_op_map(i_op_map),
    .i_op_sector(i_op_sector), .i_op_page_hi(i_op_page_hi), .i_op_wdata(i_op_wdata), .o_op_grant(o_op_grant),
    .o_op_deny(o_op_deny), .o_protect_on(o_protect_on), .o_busy(o_busy), .o_wp_filtered(o_wp_filtered),
    .o_map(o_map), .o_sector_prot(o_sector_prot));
  //////////////////////////////////////////////
  task automatic end_sim();
    $display("counts: %0d compared, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // protection level reached within 100 cycles, else the run ends
  task automatic wait_prot(input logic exp);
    int k;
    for (k = 0; k < 100 && o_protect_on !== exp; k++) tick(1);
    check({31'h0, o_protect_on}, {31'h0, exp});
    if (k == 100) end_sim();
  endtask
  // one request; exactly one grant or deny pulse is counted over two cycles
  task automatic op(input logic m, input logic [1:0] s, input logic h, input logic [31:0] d, input logic g);
    int ng;
    int nd;
    ng = 0;
    nd = 0;
    {i_op_req, i_op_map, i_op_sector, i_op_page_hi, i_op_wdata} = {1'b1, m, s, h, d};
    tick(1);
    i_op_req = 1'b0;
    repeat (2) begin
      ng += int'(o_op_grant === 1'b1);
      nd += int'(o_op_deny === 1'b1);
      tick(1);
    end
    check(32'(ng), {31'h0, g});
    check(32'(nd), {31'h0, !g});
  endtask
  task automatic cmd(input logic [31:0] w, input int n);
    host.send(w, n);
    tick(6);
  endtask
  //////////////////////////////////////////////
  task automatic t_reset();
    check(o_map, MAP_RESET);
    check({31'h0, o_protect_on}, 32'h0);
    check({27'h0, o_sector_prot}, 32'h0);
    op(1'b0, 2'h1, 1'b0, 32'h0, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_erase();
    int k;
    cmd(CMD_MAP_ERASE, 32);
    check({31'h0, o_busy}, 32'h1);
    op(1'b0, 2'h1, 1'b0, 32'h0, 1'b0);
    for (k = 0; k < ERS_CYC && o_busy === 1'b1; k++) tick(1);
    if (k == ERS_CYC) begin
      check({31'h0, o_busy}, 32'h0);
      end_sim();
    end
    check(o_map, MAP_ERASED);
    check({27'h0, o_sector_prot}, 32'h1f);
    op(1'b0, 2'h2, 1'b0, 32'h0, 1'b1);
    cmd(CMD_ENABLE, 32);
    wait_prot(1'b1);
    op(1'b0, 2'h2, 1'b0, 32'h0, 1'b0);
    op(1'b1, 2'h0, 1'b0, 32'h00ff00cf, 1'b1);
    check(o_map, 32'h00ff00cf);
    check({27'h0, o_sector_prot}, 32'h09);
    op(1'b0, 2'h0, 1'b0, 32'h0, 1'b0);
    op(1'b0, 2'h0, 1'b1, 32'h0, 1'b1);
    for (int s = 1; s < 4; s++) op(1'b0, 2'(s), 1'b0, 32'h0, s != 2);
    $display("test erase and map done");
  endtask
  task automatic t_cmds();
    cmd(CMD_DISABLE, 31);
    check({31'h0, o_protect_on}, 32'h1);
    cmd(32'h3d2a7f00, 32);
    check({31'h0, o_protect_on}, 32'h1);
    cmd(CMD_DISABLE, 32);
    wait_prot(1'b0);
    op(1'b0, 2'h2, 1'b0, 32'h0, 1'b1);
    $display("test commands done");
  endtask
  task automatic t_wp();
    logic seen;
    seen = 1'b0;
    i_wp_n = 1'b0;
    tick(3);
    i_wp_n = 1'b1;
    repeat (20) begin
      seen |= o_wp_filtered;
      tick(1);
    end
    check({31'h0, seen}, 32'h0);
    i_wp_n = 1'b0;
    wait_prot(1'b1);
    check({31'h0, o_wp_filtered}, 32'h1);
    op(1'b1, 2'h0, 1'b0, 32'h0, 1'b0);
    op(1'b0, 2'h2, 1'b0, 32'h0, 1'b0);
    cmd(CMD_MAP_ERASE, 32);
    check({31'h0, o_busy}, 32'h0);
    check(o_map, 32'h00ff00cf);
    i_wp_n = 1'b1;
    wait_prot(1'b0);
    i_wp_n = 1'b0;
    wait_prot(1'b1);
    cmd(CMD_ENABLE, 32);
    cmd(CMD_DISABLE, 32);
    i_wp_n = 1'b1;
    tick(30);
    check({31'h0, o_protect_on}, 32'h1);
    cmd(CMD_DISABLE, 32);
    wait_prot(1'b0);
    // map erase with software protection on must still run
    cmd(CMD_ENABLE, 32);
    wait_prot(1'b1);
    cmd(CMD_MAP_ERASE, 32);
    check({31'h0, o_busy}, 32'h1);
    tick(ERS_CYC);
    check({31'h0, o_busy}, 32'h0);
    check(o_map, MAP_ERASED);
    op(1'b0, 2'h3, 1'b0, 32'h0, 1'b0);
    $display("test write protect done");
  endtask
  //////////////////////////////////////////////
  initial begin
    tick(8);
    i_rst = 1'b0;
    tick(2);
    t_reset();
    t_erase();
    t_cmds();
    t_wp();
    end_sim();
  end
endmodule // tb
